// *** common/vpdc_pkg.sv ***
// package of constants for the oscillator power-down control block
// assumes a 32-bit ahb-lite register bus, word-aligned registers
package vpdc_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] PDN_CTRL_OFFS = 8'h00;
   localparam logic [7:0] PU_CTRL_OFFS = 8'h04;
   localparam logic [7:0] STATE_OFFS = 8'h08;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int OSC_BUF_BIT = 3;
   localparam int OSC_BIT = 2;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic OSC_BUF_PWRDN_RST = 1'b0;
   localparam logic OSC_BUF_PWRUP_RST = 1'b0;
   localparam logic OSC_PWRDN_RST = 1'b0;
   localparam logic OSC_PWRUP_RST = 1'b0;
   // ************************************************************
   // ahb encodings
   // ************************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;
   // ************************************************************
   // power selection
   // ************************************************************
   typedef enum logic [1:0]
   {
      VPDC_SEL_UP = 2'b00,
      VPDC_SEL_FOLLOW = 2'b01,
      VPDC_SEL_DOWN = 2'b11
   } vpdc_sel_t;
endpackage

// *** design/vpdc_pwr_sel.sv ***
// one power-state selector: pair of control bits plus modem request
// assumes all inputs are synchronous to CLK_I
module vpdc_pwr_sel
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   // controls
   input wire logic pwrdn_i,
   input wire logic pwrup_i,
   input wire logic modem_pd_i,
   // result
   output logic pd_o,
   output vpdc_pkg::vpdc_sel_t sel_o
);
   logic pd_reg;
   logic pd_next;
   vpdc_pkg::vpdc_sel_t sel_w;
   // ************************************************************
   // selection table
   // ************************************************************
   assign sel_w = !pwrup_i ? vpdc_pkg::VPDC_SEL_UP :
                  (pwrdn_i ? vpdc_pkg::VPDC_SEL_FOLLOW : vpdc_pkg::VPDC_SEL_DOWN);
   always_comb
   begin
      case (sel_w)
         vpdc_pkg::VPDC_SEL_UP: pd_next = 1'b0;
         vpdc_pkg::VPDC_SEL_FOLLOW: pd_next = modem_pd_i;
         vpdc_pkg::VPDC_SEL_DOWN: pd_next = 1'b1;
         default: pd_next = 1'b0;
      endcase
   end
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         pd_reg <= 1'b0;
      else if (ce_i)
         pd_reg <= pd_next;
   end
   assign pd_o = pd_reg;
   assign sel_o = sel_w;
endmodule // vpdc_pwr_sel

// *** design/vpdc_top.sv ***
// oscillator and oscillator-buffer power-down control with ahb-lite registers
// assumes one clock, modem request on the same clock, single word transfers
//
// Functional notes
// - buffer power-down bit at bit 3, read/write, paired with buffer power-up bit.
// - both buffer bits 1: modem request decides buffer power state.
// - buffer power-up 1, power-down 0: buffer forced powered down.
// - buffer power-up 0: buffer kept powered up, modem ignored.
// - oscillator power-down bit at bit 2, read/write, paired with power-up bit.
// - oscillator power-up 1, power-down 0: oscillator forced powered down.
// - both oscillator bits 1 follow modem; power-down 1, power-up 0 keeps up.
module vpdc_top
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic CE_I,
   // ahb-lite slave
   input wire logic HSEL_I,
   input wire logic [7:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // modem power requests
   input wire logic MODEM_OSC_PD_I,
   input wire logic MODEM_OSC_BUF_PD_I,
   // analog power-down controls
   output logic OSC_PD_O,
   output logic OSC_BUF_PD_O
);
   // ************************************************************
   // bus address phase capture
   // ************************************************************
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic osc_buf_pwrdn_reg;
   logic osc_buf_pwrdn_next;
   logic osc_buf_pwrup_reg;
   logic osc_buf_pwrup_next;
   logic osc_pwrdn_reg;
   logic osc_pwrdn_next;
   logic osc_pwrup_reg;
   logic osc_pwrup_next;
   logic osc_pd_w;
   logic osc_buf_pd_w;
   // a transfer is taken only while hready is high
   wire valid_w = HSEL_I && HREADY_I && HTRANS_I[1];
   wire rd_w = valid_w && !HWRITE_I;
   // read decode, on the address phase
   wire hit_pdn_w = HADDR_I == vpdc_pkg::PDN_CTRL_OFFS;
   wire hit_pu_w = HADDR_I == vpdc_pkg::PU_CTRL_OFFS;
   wire hit_state_w = HADDR_I == vpdc_pkg::STATE_OFFS;
   // write decode, on the data phase behind a write address phase
   wire wr_pdn_w = wr_pend_reg && (addr_reg == vpdc_pkg::PDN_CTRL_OFFS);
   wire wr_pu_w = wr_pend_reg && (addr_reg == vpdc_pkg::PU_CTRL_OFFS);
   // write data fields
   wire wdata_buf_w = HWDATA_I[vpdc_pkg::OSC_BUF_BIT];
   wire wdata_osc_w = HWDATA_I[vpdc_pkg::OSC_BIT];
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end
      else if (CE_I)
      begin
         wr_pend_reg <= valid_w && HWRITE_I;
         addr_reg <= HADDR_I;
      end
   end
   // ************************************************************
   // control bits
   // ************************************************************
   // next values: a write lands at the end of its data phase
   assign osc_buf_pwrdn_next = wr_pdn_w ? wdata_buf_w : osc_buf_pwrdn_reg;
   assign osc_pwrdn_next = wr_pdn_w ? wdata_osc_w : osc_pwrdn_reg;
   assign osc_buf_pwrup_next = wr_pu_w ? wdata_buf_w : osc_buf_pwrup_reg;
   assign osc_pwrup_next = wr_pu_w ? wdata_osc_w : osc_pwrup_reg;
   // buffer power-down bit
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         osc_buf_pwrdn_reg <= vpdc_pkg::OSC_BUF_PWRDN_RST;
      else if (CE_I)
         osc_buf_pwrdn_reg <= osc_buf_pwrdn_next;
   end
   // oscillator power-down bit
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         osc_pwrdn_reg <= vpdc_pkg::OSC_PWRDN_RST;
      else if (CE_I)
         osc_pwrdn_reg <= osc_pwrdn_next;
   end
   // buffer power-up bit
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         osc_buf_pwrup_reg <= vpdc_pkg::OSC_BUF_PWRUP_RST;
      else if (CE_I)
         osc_buf_pwrup_reg <= osc_buf_pwrup_next;
   end
   // oscillator power-up bit
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         osc_pwrup_reg <= vpdc_pkg::OSC_PWRUP_RST;
      else if (CE_I)
         osc_pwrup_reg <= osc_pwrup_next;
   end
   // ************************************************************
   // read data
   // ************************************************************
   // the two control words come from the next values, so a read right behind a write
   // returns the data of that write
   wire [31:0] pdn_word_w = (32'(osc_buf_pwrdn_next) << vpdc_pkg::OSC_BUF_BIT) |
                            (32'(osc_pwrdn_next) << vpdc_pkg::OSC_BIT);
   wire [31:0] pu_word_w = (32'(osc_buf_pwrup_next) << vpdc_pkg::OSC_BUF_BIT) |
                           (32'(osc_pwrup_next) << vpdc_pkg::OSC_BIT);
   wire [31:0] state_word_w = (32'(osc_buf_pd_w) << vpdc_pkg::OSC_BUF_BIT) |
                              (32'(osc_pd_w) << vpdc_pkg::OSC_BIT);
   // unmapped addresses read zero
   assign rdata_next = hit_pdn_w ? pdn_word_w :
                       hit_pu_w ? pu_word_w :
                       hit_state_w ? state_word_w : 32'h0000_0000;
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         rdata_reg <= 32'h0000_0000;
      else if (CE_I && rd_w)
         rdata_reg <= rdata_next;
   end
   assign HRDATA_O = rdata_reg;
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = vpdc_pkg::HRESP_OKAY;
   // ************************************************************
   // power selectors
   // ************************************************************
   // buffer: follow / forced down / kept up
   vpdc_pwr_sel u_buf_sel
   (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .ce_i(CE_I),
      .pwrdn_i(osc_buf_pwrdn_reg),
      .pwrup_i(osc_buf_pwrup_reg),
      .modem_pd_i(MODEM_OSC_BUF_PD_I),
      .pd_o(osc_buf_pd_w),
      .sel_o()
   );
   // oscillator: same pairing table
   vpdc_pwr_sel u_osc_sel
   (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .ce_i(CE_I),
      .pwrdn_i(osc_pwrdn_reg),
      .pwrup_i(osc_pwrup_reg),
      .modem_pd_i(MODEM_OSC_PD_I),
      .pd_o(osc_pd_w),
      .sel_o()
   );
   assign OSC_PD_O = osc_pd_w;
   assign OSC_BUF_PD_O = osc_buf_pd_w;
endmodule // vpdc_top

// *** testbench/vpdc_modem_model.sv ***
// modem block stand-in: registered power-down requests
// assumes the bench sets req_i just after a rising edge
module vpdc_modem_model
(
   // control
   input wire logic clk_i,
   input wire logic req_i,
   // requests, the buffer gets the inverse so a swapped path shows
   output logic osc_pd_o = 1'b0,
   output logic buf_pd_o = 1'b1
);
   always_ff @(posedge clk_i)
   begin
      osc_pd_o <= req_i;
      buf_pd_o <= !req_i;
   end
endmodule // vpdc_modem_model

// *** testbench/vpdc_props.sv ***
// assertions on the oscillator power-down control ports
// assumes it is bound to vpdc_top, one clock, modem inputs on that clock
module vpdc_props
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic CE_I,
   // bus
   input wire logic HSEL_I,
   input wire logic [7:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HRDATA_O,
   // power
   input wire logic MODEM_OSC_PD_I,
   input wire logic MODEM_OSC_BUF_PD_I,
   input wire logic OSC_PD_O,
   input wire logic OSC_BUF_PD_O
);
   // ****
   // shadow of the control bits
   // ****
   logic wr_q, rd_q;
   logic [7:0] a_q;
   logic [3:2] pd_q, pu_q;
   wire take = HSEL_I && HREADY_I && HTRANS_I[1];
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         {wr_q, rd_q, a_q, pd_q, pu_q} <= '0;
      end
      else if (CE_I)
      begin
         wr_q <= take && HWRITE_I;
         rd_q <= take && !HWRITE_I;
         a_q <= HADDR_I;
         if (wr_q && a_q == vpdc_pkg::PDN_CTRL_OFFS) pd_q <= HWDATA_I[3:2];
         if (wr_q && a_q == vpdc_pkg::PU_CTRL_OFFS) pu_q <= HWDATA_I[3:2];
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   buf_follow_a: assert property (CE_I && pu_q[3] && pd_q[3]
      |=> OSC_BUF_PD_O == $past(MODEM_OSC_BUF_PD_I)) else $error("buffer not following modem");
   buf_down_a: assert property (CE_I && pu_q[3] && !pd_q[3] |=> OSC_BUF_PD_O)
      else $error("buffer not forced down");
   buf_up_a: assert property (CE_I && !pu_q[3] |=> !OSC_BUF_PD_O)
      else $error("buffer not kept up");
   osc_down_a: assert property (CE_I && pu_q[2] && !pd_q[2] |=> OSC_PD_O)
      else $error("oscillator not forced down");
   osc_follow_a: assert property (CE_I && pu_q[2] && pd_q[2]
      |=> OSC_PD_O == $past(MODEM_OSC_PD_I)) else $error("oscillator not following modem");
   osc_up_a: assert property (CE_I && !pu_q[2] |=> !OSC_PD_O)
      else $error("oscillator not kept up");
   pdn_read_a: assert property (rd_q && a_q == vpdc_pkg::PDN_CTRL_OFFS
      |-> HRDATA_O == {28'h0000000, pd_q, 2'h0}) else $error("power-down readback wrong");
   pu_read_a: assert property (rd_q && a_q == vpdc_pkg::PU_CTRL_OFFS
      |-> HRDATA_O == {28'h0000000, pu_q, 2'h0}) else $error("power-up readback wrong");
endmodule // vpdc_props

// *** testbench/vpdc_top_tb.sv ***
// self-checking bench for the oscillator power-down control block
// assumes a zero-wait ahb-lite slave and the modem stand-in
module vpdc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_I = 1'b0, RESET_N_I = 1'b0, CE_I = 1'b1, HSEL_I = 1'b0, HWRITE_I = 1'b0, req = 1'b0;
   logic [7:0] HADDR_I = 8'h00;
   logic [1:0] HTRANS_I = 2'h0;
   logic [2:0] HSIZE_I = 3'h2;
   logic [31:0] HWDATA_I = 32'h0, HRDATA_O, rd;
   logic HREADYOUT_O, HRESP_O, mosc, mbuf, OSC_PD_O, OSC_BUF_PD_O, pd, pu, eo, eb;
   int num_errors = 0, check_count = 0, cyc = 0;
   vpdc_top u_vpdc_top (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I), .HSEL_I(HSEL_I),
      .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I),
      .HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O),
      .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .MODEM_OSC_PD_I(mosc),
      .MODEM_OSC_BUF_PD_I(mbuf), .OSC_PD_O(OSC_PD_O), .OSC_BUF_PD_O(OSC_BUF_PD_O));
   vpdc_modem_model u_vpdc_modem_model (.clk_i(CLK_I), .req_i(req), .osc_pd_o(mosc),
      .buf_pd_o(mbuf));
   initial forever #4 CLK_I = ~CLK_I;
   always @(posedge CLK_I)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         num_errors++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one single transfer, then an idle cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      HSEL_I <= 1'b1;
      HADDR_I <= a;
      HWRITE_I <= w;
      HTRANS_I <= vpdc_pkg::HTRANS_NONSEQ;
      do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
      HTRANS_I <= 2'h0;
      HWDATA_I <= wd;
      do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
      rd = HRDATA_O;
      check("bus response", {31'h0, HRESP_O}, {31'h0, vpdc_pkg::HRESP_OKAY});
      HSEL_I <= 1'b0;
      @(posedge CLK_I);
   endtask
   // a write, then a read of the same word with no idle cycle between them
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] wd);
      HSEL_I <= 1'b1;
      HADDR_I <= a;
      HWRITE_I <= 1'b1;
      HTRANS_I <= vpdc_pkg::HTRANS_NONSEQ;
      do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
      HWRITE_I <= 1'b0;
      HWDATA_I <= wd;
      do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
      HTRANS_I <= 2'h0;
      do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
      rd = HRDATA_O;
      HSEL_I <= 1'b0;
      @(posedge CLK_I);
   endtask
   initial
   begin
      repeat (4) @(posedge CLK_I);
      RESET_N_I <= 1'b1;
      @(posedge CLK_I);
      for (int a = 0; a < 16; a += 4)
      begin
         bus(1'b0, 8'(a), 32'h0);
         check("reset read", rd, 32'h0);
      end
      $display("test reset done");
      bus(1'b1, vpdc_pkg::PDN_CTRL_OFFS, 32'hffffffff);
      bus(1'b1, 8'h0c, 32'hffffffff);
      bus(1'b1, vpdc_pkg::PU_CTRL_OFFS, 32'h00000008);
      bus(1'b0, vpdc_pkg::PDN_CTRL_OFFS, 32'h0);
      check("pwrdn read", rd, 32'h0000000c);
      bus(1'b0, vpdc_pkg::PU_CTRL_OFFS, 32'h0);
      check("pwrup read", rd, 32'h00000008);
      bus(1'b0, 8'h0c, 32'h0);
      check("unmapped read", rd, 32'h0);
      $display("test registers done");
      for (int k = 0; k < 8; k++)
      begin
         {pu, pd} = 2'(k >> 1);
         req <= k[0];
         bus(1'b1, vpdc_pkg::PDN_CTRL_OFFS, {28'h0000000, pd, pd, 2'h0});
         bus(1'b1, vpdc_pkg::PU_CTRL_OFFS, {28'h0000000, pu, pu, 2'h0});
         repeat (3) @(posedge CLK_I);
         eo = pu & (!pd | req);
         eb = pu & (!pd | !req);
         check("osc pd", {31'h0, OSC_PD_O}, {31'h0, eo});
         check("buf pd", {31'h0, OSC_BUF_PD_O}, {31'h0, eb});
         bus(1'b0, vpdc_pkg::STATE_OFFS, 32'h0);
         check("state read", rd, {28'h0000000, eb, eo, 2'h0});
      end
      $display("test power table done");
      // last table entry follows the modem: osc down, buffer up; freeze it
      CE_I <= 1'b0;
      req <= 1'b0;
      repeat (4) @(posedge CLK_I);
      check("osc pd frozen", {31'h0, OSC_PD_O}, 32'h1);
      check("buf pd frozen", {31'h0, OSC_BUF_PD_O}, 32'h0);
      CE_I <= 1'b1;
      repeat (3) @(posedge CLK_I);
      check("osc pd resumed", {31'h0, OSC_PD_O}, 32'h0);
      check("buf pd resumed", {31'h0, OSC_BUF_PD_O}, 32'h1);
      $display("test clock enable done");
      RESET_N_I <= 1'b0;
      repeat (2) @(posedge CLK_I);
      check("osc pd in reset", {31'h0, OSC_PD_O}, 32'h0);
      check("buf pd in reset", {31'h0, OSC_BUF_PD_O}, 32'h0);
      RESET_N_I <= 1'b1;
      @(posedge CLK_I);
      bus(1'b0, vpdc_pkg::PU_CTRL_OFFS, 32'h0);
      check("pwrup after reset", rd, 32'h0);
      wr_rd(vpdc_pkg::PDN_CTRL_OFFS, 32'h00000004);
      check("pwrdn read behind write", rd, 32'h00000004);
      $display("test reset and back-to-back done");
      end_sim();
   end
endmodule // vpdc_top_tb
bind vpdc_top vpdc_props u_vpdc_props (.*);
